// ===== rtl/dmam_top.sv
`timescale 1ns/100ps
`default_nettype none

module dmam_top
  import dmam_pkg::*;
(
  input  wire logic              I_CLK,
  input  wire logic              I_RST_B,
  // address requests from the instruction sequencer
  input  wire logic              I_REQ_VALID,
  input  wire dmam_req_t         I_REQ,
  output logic                   O_ANS_VALID,
  output dmam_ans_t              O_ANS,
  // AXI4-Lite register port
  input  wire logic [AXI_AW-1:0] I_AWADDR,
  input  wire logic [2:0]        I_AWPROT,
  input  wire logic              I_AWVALID,
  output logic                   O_AWREADY,
  input  wire logic [AXI_DW-1:0] I_WDATA,
  input  wire logic [AXI_SW-1:0] I_WSTRB,
  input  wire logic              I_WVALID,
  output logic                   O_WREADY,
  output logic [1:0]             O_BRESP,
  output logic                   O_BVALID,
  input  wire logic              I_BREADY,
  input  wire logic [AXI_AW-1:0] I_ARADDR,
  input  wire logic [2:0]        I_ARPROT,
  input  wire logic              I_ARVALID,
  output logic                   O_ARREADY,
  output logic [AXI_DW-1:0]      O_RDATA,
  output logic [1:0]             O_RRESP,
  output logic                   O_RVALID,
  input  wire logic              I_RREADY
);

  // register decode, shared by the write and read paths
  function automatic logic [3:0] reg_sel(input logic [AXI_AW-1:0] a);
    logic [AXI_AW-1:0] w;
    w = {a[AXI_AW-1:2], 2'b00};
    reg_sel = {w == REG_STATUS, w == REG_POINTER, w == REG_OFFSET, w == REG_CTRL};
  endfunction : reg_sel

  logic [CTRL_W-1:0]  ctrl;
  logic [ADDR_W-1:0]  offset;
  logic [PTR_W-1:0]   pointer;
  dmam_ans_t          last_ans;
  logic               ind_seen;

  dmam_wstate_t       wstate;
  logic               aw_have;
  logic               w_have;
  logic [AXI_AW-1:0]  aw_addr;
  logic [AXI_DW-1:0]  w_data;
  logic [AXI_SW-1:0]  w_strb;
  dmam_rstate_t       rstate;

  wire                ptr_en;
  wire                idx_en;
  wire [AXI_DW-1:0]   wmask;
  wire [3:0]          wsel;
  wire [3:0]          rsel;
  wire                aw_take;
  wire                w_take;
  wire                both_have;
  wire                do_write;
  wire                w_mapped;
  wire                ar_take;
  wire [AXI_DW-1:0]   merge_ctrl;
  wire [AXI_DW-1:0]   merge_offset;
  wire [AXI_DW-1:0]   merge_pointer;
  wire [AXI_DW-1:0]   status_word;
  wire [AXI_DW-1:0]   rd_word;
  wire [1:0]          rd_resp;
  dmam_ans_t          calc_ans;

  // register views and per-register write strobes
  wire [AXI_DW-1:0]   rd_ctrl;
  wire [AXI_DW-1:0]   rd_offset;
  wire [AXI_DW-1:0]   rd_pointer;

  wire                wr_ctrl;
  wire                wr_offset;
  wire                wr_pointer;
  wire                mode_ptr;
  wire                mode_idx;
  wire                mode_conflict;
  wire [ADDR_W-1:0]   st_direct;
  wire [ADDR_W-1:0]   st_indirect;

  // flags and address computation

  assign ptr_en = ctrl[CTRL_PTR_EN_BIT];
  assign idx_en = ctrl[CTRL_IDX_EN_BIT];

  dmam_calc u_calc (
    .i_ptr_en  (ptr_en),
    .i_idx_en  (idx_en),
    .i_offset  (offset),
    .i_pointer (pointer),
    .i_req     (I_REQ),
    .o_ans     (calc_ans)
  );

  // registered answer: one cycle after the request, data held until the next
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_ANS_VALID <= 1'b0;
      O_ANS       <= '0;
    end else begin
      O_ANS_VALID <= I_REQ_VALID;
      if (I_REQ_VALID) begin
        O_ANS <= calc_ans;
      end
    end
  end

  // last answers kept for software inspection
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      last_ans <= '0;
      ind_seen <= 1'b0;
    end else if (I_REQ_VALID) begin
      last_ans <= calc_ans;
      ind_seen <= calc_ans.indirect;
    end
  end

  // write channel: address and data taken in either order, held until both

  assign aw_take   = I_AWVALID & O_AWREADY;
  assign w_take    = I_WVALID & O_WREADY;
  assign O_AWREADY = (wstate == WS_COLLECT) & ~aw_have;
  assign O_WREADY  = (wstate == WS_COLLECT) & ~w_have;
  assign both_have = (aw_have | aw_take) & (w_have | w_take);
  assign do_write  = (wstate == WS_COLLECT) & both_have;

  wire [AXI_AW-1:0] wr_addr = aw_have ? aw_addr : I_AWADDR;
  wire [AXI_DW-1:0] wr_data = w_have ? w_data : I_WDATA;
  wire [AXI_SW-1:0] wr_strb = w_have ? w_strb : I_WSTRB;

  assign wsel     = reg_sel(wr_addr);
  assign w_mapped = |wsel;

  genvar lane;
  generate
    for (lane = 0; lane < AXI_SW; lane++) begin : g_lane
      assign wmask[8*lane +: 8] = {8{wr_strb[lane]}};
    end
  endgenerate

  // registers zero-extended to the bus word, shared by write merge and read mux
  assign rd_ctrl    = {{(AXI_DW-CTRL_W){1'b0}}, ctrl};
  assign rd_offset  = {{(AXI_DW-ADDR_W){1'b0}}, offset};
  assign rd_pointer = {{(AXI_DW-PTR_W){1'b0}}, pointer};

  assign merge_ctrl    = (rd_ctrl & ~wmask) | (wr_data & wmask);
  assign merge_offset  = (rd_offset & ~wmask) | (wr_data & wmask);
  assign merge_pointer = (rd_pointer & ~wmask) | (wr_data & wmask);

  // status has no strobe, so a write to it is acknowledged and dropped
  assign wr_ctrl    = do_write & wsel[0];
  assign wr_offset  = do_write & wsel[1];
  assign wr_pointer = do_write & wsel[2];

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      if (aw_take) begin
        aw_addr <= I_AWADDR;
      end
      if (w_take) begin
        w_data <= I_WDATA;
        w_strb <= I_WSTRB;
      end
      aw_have <= ~do_write & (aw_have | aw_take);
      w_have  <= ~do_write & (w_have | w_take);
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      wstate   <= WS_COLLECT;
      O_BVALID <= 1'b0;
      O_BRESP  <= RESP_OKAY;
    end else begin
      case (wstate)
        WS_COLLECT: begin
          if (do_write) begin
            wstate   <= WS_RESP;
            O_BVALID <= 1'b1;
            O_BRESP  <= w_mapped ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WS_RESP: begin
          if (I_BREADY) begin
            wstate   <= WS_COLLECT;
            O_BVALID <= 1'b0;
          end
        end
        default: begin
          wstate   <= WS_COLLECT;
          O_BVALID <= 1'b0;
        end
      endcase
    end
  end

  // control state; status is read-only so a write to it changes nothing
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctrl    <= CTRL_RST;
      offset  <= OFFSET_RST;
      pointer <= POINTER_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl <= merge_ctrl[CTRL_W-1:0];
      end
      if (wr_offset) begin
        offset <= merge_offset[ADDR_W-1:0];
      end
      if (wr_pointer) begin
        pointer <= merge_pointer[PTR_W-1:0];
      end
    end
  end

  // read channel

  assign O_ARREADY = (rstate == RS_IDLE);
  assign ar_take   = I_ARVALID & O_ARREADY;
  assign rsel      = reg_sel(I_ARADDR);

  // conflict bit flags the undefined both-flags setting for software
  assign mode_ptr      = ptr_en & ~idx_en;
  assign mode_idx      = idx_en & ~ptr_en;
  assign mode_conflict = ptr_en & idx_en;
  assign st_direct     = last_ans.direct;
  assign st_indirect   = last_ans.indirect_addr;

  assign status_word = ({{(AXI_DW-ADDR_W){1'b0}}, st_direct} << ST_DIRECT_LSB)
                     | ({{(AXI_DW-ADDR_W){1'b0}}, st_indirect} << ST_INDIRECT_LSB)
                     | ({{(AXI_DW-1){1'b0}}, ind_seen} << ST_IND_SEEN_BIT)
                     | ({{(AXI_DW-1){1'b0}}, mode_ptr} << ST_PTR_ACT_BIT)
                     | ({{(AXI_DW-1){1'b0}}, mode_idx} << ST_IDX_ACT_BIT)
                     | ({{(AXI_DW-1){1'b0}}, mode_conflict} << ST_CONFLICT_BIT);

  assign rd_word = rsel[0] ? rd_ctrl :
                   rsel[1] ? rd_offset :
                   rsel[2] ? rd_pointer :
                   rsel[3] ? status_word : {AXI_DW{1'b0}};
  assign rd_resp = (|rsel) ? RESP_OKAY : RESP_SLVERR;

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rstate   <= RS_IDLE;
      O_RVALID <= 1'b0;
      O_RDATA  <= '0;
      O_RRESP  <= RESP_OKAY;
    end else begin
      case (rstate)
        RS_IDLE: begin
          if (ar_take) begin
            rstate   <= RS_DATA;
            O_RVALID <= 1'b1;
            O_RDATA  <= rd_word;
            O_RRESP  <= rd_resp;
          end
        end
        RS_DATA: begin
          if (I_RREADY) begin
            rstate   <= RS_IDLE;
            O_RVALID <= 1'b0;
          end
        end
        default: begin
          rstate   <= RS_IDLE;
          O_RVALID <= 1'b0;
        end
      endcase
    end
  end

  // protection attributes carry no meaning for this block
  wire unused_prot = ^{I_AWPROT, I_ARPROT};

endmodule : dmam_top

`default_nettype wire

// ===== rtl/dmam_pkg.sv
package dmam_pkg;

  // address geometry
  localparam int BANK_W = 4;
  localparam int ROW_W  = 3;
  localparam int COL_W  = 4;
  localparam int ADDR_W = BANK_W + ROW_W + COL_W;
  localparam int PTR_W  = BANK_W + ROW_W;

  // bus geometry
  localparam int AXI_AW = 12;
  localparam int AXI_DW = 32;
  localparam int AXI_SW = AXI_DW / 8;

  // register byte offsets
  localparam logic [AXI_AW-1:0] REG_CTRL    = 12'h000;
  localparam logic [AXI_AW-1:0] REG_OFFSET  = 12'h004;
  localparam logic [AXI_AW-1:0] REG_POINTER = 12'h008;
  localparam logic [AXI_AW-1:0] REG_STATUS  = 12'h00c;

  // control register fields
  localparam int CTRL_IDX_EN_BIT = 0;
  localparam int CTRL_PTR_EN_BIT = 1;
  localparam int CTRL_W          = 2;

  // offset register parts: high 10..8, middle 7..4, low 3..0
  localparam int OFF_HIGH_LSB = 8;
  localparam int OFF_MID_LSB  = 4;
  localparam int OFF_LOW_LSB  = 0;

  // row pointer parts: high nibble holds bits 6..4, low nibble bits 3..0
  localparam int PTR_HIGH_LSB = 4;
  localparam int PTR_LOW_LSB  = 0;

  // status register fields
  localparam int ST_DIRECT_LSB   = 0;
  localparam int ST_INDIRECT_LSB = 16;
  localparam int ST_IND_SEEN_BIT = 28;
  localparam int ST_PTR_ACT_BIT  = 29;
  localparam int ST_IDX_ACT_BIT  = 30;
  localparam int ST_CONFLICT_BIT = 31;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST    = 2'h0;
  localparam logic [ADDR_W-1:0] OFFSET_RST  = 11'h000;
  localparam logic [PTR_W-1:0]  POINTER_RST = 7'h00;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0]  row;
    logic [COL_W-1:0]  col;
  } dmam_addr_t;

  typedef enum logic [2:0] {
    OP_DIRECT    = 3'b001,
    OP_IND_STORE = 3'b010,
    OP_IND_LOAD  = 3'b100
  } dmam_op_t;

  typedef struct packed {
    dmam_op_t         op;
    dmam_addr_t       direct;
    logic [COL_W-1:0] gr_col;
  } dmam_req_t;

  typedef struct packed {
    logic       indirect;
    dmam_addr_t direct;
    dmam_addr_t indirect_addr;
  } dmam_ans_t;

  typedef enum logic [1:0] {
    WS_COLLECT = 2'b01,
    WS_RESP    = 2'b10
  } dmam_wstate_t;

  typedef enum logic [1:0] {
    RS_IDLE = 2'b01,
    RS_DATA = 2'b10
  } dmam_rstate_t;

endpackage : dmam_pkg

// ===== rtl/dmam_calc.sv
`timescale 1ns/100ps
`default_nettype none

module dmam_calc
  import dmam_pkg::*;
(
  input  wire logic             i_ptr_en,
  input  wire logic             i_idx_en,
  input  wire logic [ADDR_W-1:0] i_offset,
  input  wire logic [PTR_W-1:0]  i_pointer,
  input  wire dmam_req_t        i_req,
  output dmam_ans_t             o_ans
);

  wire                mod_active;
  wire                ptr_active;
  wire                indirect_op;
  wire [ADDR_W-1:0]   direct_real;
  wire [PTR_W-1:0]    ind_bank_row;
  wire [ADDR_W-1:0]   mod_mask;

  // both flags set is left unmodified rather than guessing a combination
  assign mod_active  = i_idx_en & ~i_ptr_en;
  assign ptr_active  = i_ptr_en & ~i_idx_en;
  assign indirect_op = (i_req.op == OP_IND_STORE) || (i_req.op == OP_IND_LOAD);

  // fields line up bit for bit, so an OR never carries across fields
  assign mod_mask    = mod_active ? i_offset : {ADDR_W{1'b0}};
  assign direct_real = i_req.direct | mod_mask;

  // pointer only for the two indirect moves; else the (modified) direct bank/row
  assign ind_bank_row = (ptr_active && indirect_op) ? i_pointer
                                                    : direct_real[ADDR_W-1:COL_W];

  assign o_ans.indirect      = indirect_op;
  assign o_ans.direct        = direct_real;
  assign o_ans.indirect_addr = {ind_bank_row, i_req.gr_col};

endmodule : dmam_calc

`default_nettype wire

// ===== testbench/dmam_top_sva.sv
`timescale 1ns/100ps
`default_nettype none

module dmam_top_sva
  import dmam_pkg::*;
(
  input wire logic              I_CLK,
  input wire logic              I_RST_B,
  input wire logic              I_REQ_VALID,
  input wire dmam_req_t         I_REQ,
  input wire logic              O_ANS_VALID,
  input wire dmam_ans_t         O_ANS,
  input wire logic              I_ARVALID,
  input wire logic              O_ARREADY,
  input wire logic              O_RVALID,
  input wire logic              I_RREADY,
  input wire logic [AXI_DW-1:0] O_RDATA,
  input wire logic              O_BVALID,
  input wire logic              I_BREADY,
  input wire logic [1:0]        O_BRESP
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);

  chk_ans_next: assert property (I_REQ_VALID |=> O_ANS_VALID)
    else $error("no answer after request");
  chk_ans_quiet: assert property (!I_REQ_VALID |=> !O_ANS_VALID && $stable(O_ANS))
    else $error("answer moved without request");
  chk_col_pass: assert property (I_REQ_VALID |=> O_ANS.indirect_addr.col == $past(I_REQ.gr_col))
    else $error("indirect column differs from register nibble");
  chk_or_only: assert property (I_REQ_VALID |=> (O_ANS.direct | $past(I_REQ.direct)) == O_ANS.direct)
    else $error("modified address lost an operand bit");
  chk_ind_flag: assert property (I_REQ_VALID |=> O_ANS.indirect == ($past(I_REQ.op) != OP_DIRECT))
    else $error("indirect flag wrong");
  chk_direct_row: assert property (I_REQ_VALID && I_REQ.op == OP_DIRECT |=>
    {O_ANS.indirect_addr.bank, O_ANS.indirect_addr.row} == {O_ANS.direct.bank, O_ANS.direct.row})
    else $error("pointer used for a direct operation");
  chk_b_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped early");
  chk_r_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data dropped early");
  chk_read_ans: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read answer late");

  cov_ind: cover property (I_REQ_VALID && I_REQ.op != OP_DIRECT);
  cov_b2b: cover property (I_REQ_VALID [*2]);
  cov_rwait: cover property (O_RVALID && !I_RREADY);
endmodule : dmam_top_sva

bind dmam_top dmam_top_sva u_dmam_top_sva (.I_CLK, .I_RST_B, .I_REQ_VALID, .I_REQ,
  .O_ANS_VALID, .O_ANS, .I_ARVALID, .O_ARREADY, .O_RVALID, .I_RREADY, .O_RDATA,
  .O_BVALID, .I_BREADY, .O_BRESP);

`default_nettype wire

// ===== testbench/dmam_seq_model.sv
`timescale 1ns/100ps
`default_nettype none

module dmam_seq_model
  import dmam_pkg::*;
(
  input  wire logic    i_clk,
  output var logic     o_valid,
  output var dmam_req_t o_req
);
  dmam_req_t q[$];

  initial begin
    o_valid = 1'b0;
    o_req   = '0;
  end

  // issues queued requests back to back; idle cycles scramble the operand lines
  always @(posedge i_clk) begin
    o_valid <= q.size() != 0;
    if (q.size() != 0) o_req <= q.pop_front();
    else o_req <= ~o_req;
  end
endmodule : dmam_seq_model

`default_nettype wire

// ===== testbench/dmam_top_tb.sv
`timescale 1ns/100ps
`default_nettype none

module dmam_top_tb
  import dmam_pkg::*;
;
  logic clk = 0, rst_b = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
  logic [AXI_DW-1:0] wdata = '0, r32, rdata;
  logic req_v, ans_v, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, ctl;
  logic [10:0] ofs;
  logic [6:0] ptr;
  dmam_req_t req, rq;
  dmam_ans_t ans, last;
  dmam_ans_t expq[$];
  int errors = 0, n_compared = 0, seed = 32'h3f74, c, i;

  dmam_top u_dmam_top (.I_CLK(clk), .I_RST_B(rst_b), .I_REQ_VALID(req_v), .I_REQ(req),
    .O_ANS_VALID(ans_v), .O_ANS(ans), .I_AWADDR(awaddr), .I_AWPROT(3'h0), .I_AWVALID(awv),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wv), .O_WREADY(wready),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
    .I_ARPROT(3'h0), .I_ARVALID(arv), .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
    .O_RVALID(rvalid), .I_RREADY(rready));
  dmam_seq_model u_dmam_seq_model (.i_clk(clk), .o_valid(req_v), .o_req(req));

  always #4 clk = ~clk;

  function automatic dmam_ans_t model(logic [1:0] f, logic [10:0] o, logic [6:0] p, dmam_req_t r);
    dmam_ans_t a;
    a.indirect = r.op != OP_DIRECT;
    a.direct = r.direct | (f == 2'h1 ? o : 11'h0);
    a.indirect_addr = {(f == 2'h2 && a.indirect) ? p : a.direct[10:4], r.gr_col};
    return a;
  endfunction : model

  task summarize;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task tmo(input logic ok);
    if (!ok) begin
      errors++;
      summarize();
    end
  endtask : tmo

  task axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic da, dw;
    int n;
    da = 0;
    dw = 0;
    awaddr <= a;
    wdata <= d;
    awv <= 1;
    wv <= 1;
    for (n = 0; n < 40 && !(da && dw); n++) begin
      @(negedge clk);
      if (awv && awready) da = 1;
      if (wv && wready) dw = 1;
      @(posedge clk);
      if (da) awv <= 0;
      if (dw) wv <= 0;
    end
    tmo(da && dw);
    // one cycle with bready low so the response must wait
    @(posedge clk);
    bready <= 1;
    n = 0;
    do @(negedge clk); while (bvalid !== 1'b1 && ++n < 40);
    tmo(n < 40);
    check({30'h0, bresp}, {30'h0, er});
    @(posedge clk);
    bready <= 0;
  endtask : axw

  task axr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    araddr <= a;
    arv <= 1;
    n = 0;
    do @(negedge clk); while (arready !== 1'b1 && ++n < 40);
    tmo(n < 40);
    @(posedge clk);
    arv <= 0;
    @(posedge clk);
    rready <= 1;
    n = 0;
    do @(negedge clk); while (rvalid !== 1'b1 && ++n < 40);
    tmo(n < 40);
    check(rdata, d);
    check({30'h0, rresp}, {30'h0, er});
    @(posedge clk);
    rready <= 0;
  endtask : axr

  task drain;
    int n;
    for (n = 0; n < 40 && expq.size() != 0; n++) @(posedge clk);
    tmo(expq.size() == 0);
  endtask : drain

  always @(negedge clk) begin
    if (ans_v === 1'b1) begin
      check({9'h0, ans}, expq.size() ? {9'h0, expq.pop_front()} : 32'hffffffff);
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    for (i = 0; i < 4; i++) axr(12'(i * 4), 32'h0, RESP_OKAY);
    axr(12'h010, 32'h0, RESP_SLVERR);
    axw(12'h010, 32'hffffffff, RESP_SLVERR);
    axr(REG_CTRL, 32'h0, RESP_OKAY);
    for (c = 0; c < 4; c++) begin
      r32 = $random(seed);
      ofs = r32[10:0];
      axw(REG_OFFSET, r32, RESP_OKAY);
      axr(REG_OFFSET, {21'h0, ofs}, RESP_OKAY);
      r32 = $random(seed);
      ptr = r32[6:0];
      axw(REG_POINTER, r32, RESP_OKAY);
      axr(REG_POINTER, {25'h0, ptr}, RESP_OKAY);
      ctl = 2'(c % 3);
      axw(REG_CTRL, {30'h0, ctl}, RESP_OKAY);
      for (i = 0; i < 12; i++) begin
        r32 = $random(seed);
        rq.op = dmam_op_t'(3'b001 << (i % 3));
        rq.direct = r32[10:0];
        rq.gr_col = r32[14:11];
        last = model(ctl, ofs, ptr, rq);
        expq.push_back(last);
        u_dmam_seq_model.q.push_back(rq);
      end
      drain();
      if (ctl != 2'h3) axr(REG_STATUS, {1'b0, ctl == 2'h1, ctl == 2'h2, last.indirect, 1'b0,
        last.indirect_addr, 5'h0, last.direct}, RESP_OKAY);
    end
    axw(REG_OFFSET, 32'h012, RESP_OKAY);
    axw(REG_CTRL, 32'h1, RESP_OKAY);
    rq = {OP_DIRECT, 11'h061, 4'h0};
    expq.push_back({1'b0, 11'h073, 7'h07, 4'h0});
    u_dmam_seq_model.q.push_back(rq);
    drain();
    summarize();
  end
endmodule : dmam_top_tb

`default_nettype wire
